// ===== bench/rtca_regs_props.sv
// concurrent checks on the ports of the calendar register block
`timescale 1ns/1ps
`include "rtca_consts.svh"
module rtca_regs_props (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [`RTCA_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // control and status
  input wire logic binary_presentation_select,
  input wire logic hour_format_24,
  input wire logic update_inhibit,
  input wire logic sec_tick,
  input wire logic alarm_evt,
  input wire logic update_busy
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // a tick only counts while the chain is idle and not inhibited
  wire tick_ok = sec_tick && !update_inhibit && !update_busy;
  wire hr_wr = reg_wr && reg_addr == `RTCA_OFS_HOUR && hour_format_24 && !update_busy;
  wire wd_wr = reg_wr && reg_addr == `RTCA_OFS_WEEKDAY && !update_busy && !sec_tick;

  a_tick_starts_chain: assert property (tick_ok |=> update_busy)
    else $error("chain did not start on tick");
  a_inhibit_holds_idle: assert property (
    sec_tick && update_inhibit && !update_busy |=> !update_busy)
    else $error("chain started while inhibited");
  a_busy_has_cause: assert property (
    $rose(update_busy) |-> $past(sec_tick) && !$past(update_inhibit))
    else $error("chain started without tick");
  a_chain_bounded: assert property ($rose(update_busy) |-> ##[1:10] !update_busy)
    else $error("chain ran too long");
  // alarm only at end of chain
  a_alarm_ends_chain: assert property (alarm_evt |-> $fell(update_busy))
    else $error("alarm outside chain end");
  a_min_match_store: assert property (
    reg_wr && reg_addr == `RTCA_OFS_MIN_MATCH ##2 reg_rd && reg_addr == `RTCA_OFS_MIN_MATCH
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("minute match readback wrong");
  a_hour_flag_zero: assert property (
    hr_wr && !sec_tick ##2 reg_rd && reg_addr == `RTCA_OFS_HOUR && !update_busy
    |=> !reg_rdata[`RTCA_HALF_DAY_BIT])
    else $error("half-day flag set in 24h");
  a_weekday_store: assert property (
    wd_wr ##2 reg_rd && reg_addr == `RTCA_OFS_WEEKDAY && !update_busy
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("weekday readback wrong");

  c_tick: cover property (tick_ok);
  c_alarm: cover property (alarm_evt);
  c_hour24: cover property (hr_wr);
endmodule

bind rtca_regs rtca_regs_props i_rtca_regs_props (.clk_sys, .rstn, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .binary_presentation_select, .hour_format_24,
  .update_inhibit, .sec_tick, .alarm_evt, .update_busy);

// ===== bench/tb_rtca_regs.sv
// self-checking bench for the calendar register block
`timescale 1ns/1ps
`include "rtca_consts.svh"
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      err_total++; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); \
    end \
  end
module tb_rtca_regs;
  // row order: sec, min, hour, weekday, date, month, year
  typedef logic [7:0] rtca_row_t [7];
  logic clk_sys;
  logic rstn;
  logic [`RTCA_ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic bin_sel;
  logic fmt24;
  logic inhibit;
  logic sec_tick;
  logic alarm_evt;
  logic update_busy;
  logic seen_alarm;
  int err_total;
  int samples_checked;
  logic [5:0] ofs [7] = '{6'h00, 6'h02, 6'h04, 6'h06, 6'h07, 6'h08, 6'h09};

  rtca_regs i_rtca_regs (.clk_sys, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .binary_presentation_select(bin_sel), .hour_format_24(fmt24),
    .update_inhibit(inhibit), .sec_tick, .alarm_evt, .update_busy);

  initial begin
    clk_sys = 0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // an idle cycle after each strobe keeps drivers from double assignment
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(posedge clk_sys);
    #1;
    reg_wr = 0;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic chk_rd(input string nm, input logic [5:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1;
    @(posedge clk_sys);
    #1;
    reg_rd = 0;
    `CHK(nm, e, reg_rdata)
    @(posedge clk_sys);
    #1;
  endtask

  task automatic put(input rtca_row_t v);
    for (int i = 0; i < 7; i++) wr(ofs[i], v[i]);
  endtask

  task automatic want(input string nm, input rtca_row_t v);
    for (int i = 0; i < 7; i++) chk_rd(nm, ofs[i], v[i]);
  endtask

  // ticks are spaced well apart so none is lost to a running chain
  task automatic tick(input logic exp_run);
    logic st;
    st = 0;
    seen_alarm = 0;
    repeat (10) @(posedge clk_sys);
    #1;
    sec_tick = 1;
    @(posedge clk_sys);
    #1;
    sec_tick = 0;
    for (int i = 0; i < 20; i++) begin
      if (alarm_evt === 1'b1) seen_alarm = 1;
      if (update_busy === 1'b1) st = 1;
      else if (st) break;
      @(posedge clk_sys);
      #1;
    end
    // a chain that never ends counts as a mismatch; the run still reaches close_out
    if (update_busy !== 1'b0) begin
      `CHK("chain end", 1'b0, update_busy)
    end
    `CHK("chain run", exp_run, st)
  endtask

  task automatic t_reset();
    for (int a = 0; a < 10; a++) chk_rd("reset", 6'(a), 8'h00);
    wr(6'h0A, 8'h55);
    chk_rd("unmapped", 6'h0A, 8'h00);
  endtask

  task automatic t_alarm();
    logic [7:0] sm [7] = '{8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'hC0, 8'h16, 8'h20};
    logic [7:0] mm [7] = '{8'h12, 8'h13, 8'hC5, 8'hC0, 8'hC0, 8'hC0, 8'hC0};
    logic [7:0] hm [7] = '{8'hC0, 8'hC0, 8'hC0, 8'h05, 8'h06, 8'hC0, 8'hC0};
    logic ex [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    put('{8'h10, 8'h12, 8'h05, 8'h01, 8'h01, 8'h01, 8'h00});
    // seconds reach 11+i after tick i, so the last two rows try the seconds term
    for (int i = 0; i < 7; i++) begin
      wr(6'h01, sm[i]);
      wr(6'h05, hm[i]);
      wr(6'h03, mm[i]);
      chk_rd("min match", 6'h03, mm[i]);
      tick(1);
      `CHK("alarm", ex[i], seen_alarm)
    end
  endtask

  task automatic t_calendar();
    put('{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99});
    tick(1);
    want("bcd carry", '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00});
    bin_sel = 1;
    put('{8'h3B, 8'h3B, 8'h17, 8'h07, 8'h1F, 8'h0C, 8'h09});
    tick(1);
    want("bin carry", '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h0A});
    bin_sel = 0;
  endtask

  task automatic t_twelve();
    fmt24 = 0;
    put('{8'h59, 8'h59, 8'h11, 8'h03, 8'h28, 8'h02, 8'h01});
    tick(1);
    want("noon", '{8'h00, 8'h00, 8'h92, 8'h03, 8'h28, 8'h02, 8'h01});
    put('{8'h59, 8'h59, 8'h91, 8'h03, 8'h28, 8'h02, 8'h01});
    tick(1);
    want("midnight", '{8'h00, 8'h00, 8'h12, 8'h04, 8'h01, 8'h03, 8'h01});
    put('{8'h59, 8'h59, 8'h91, 8'h03, 8'h28, 8'h02, 8'h04});
    tick(1);
    want("leap", '{8'h00, 8'h00, 8'h12, 8'h04, 8'h29, 8'h02, 8'h04});
    fmt24 = 1;
    wr(6'h04, 8'h85);
    chk_rd("hour 24h", 6'h04, 8'h05);
    wr(6'h06, 8'h07);
    chk_rd("weekday", 6'h06, 8'h07);
  endtask

  task automatic t_inhibit();
    inhibit = 1;
    put('{8'h20, 8'h30, 8'h10, 8'h02, 8'h15, 8'h06, 8'h25});
    tick(0);
    want("inhibit", '{8'h20, 8'h30, 8'h10, 8'h02, 8'h15, 8'h06, 8'h25});
    inhibit = 0;
  endtask

  initial begin
    rstn = 0;
    reg_addr = 6'h00;
    reg_wdata = 8'h00;
    reg_wr = 0;
    reg_rd = 0;
    bin_sel = 0;
    fmt24 = 1;
    inhibit = 0;
    sec_tick = 0;
    seen_alarm = 0;
    err_total = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk_sys);
    #1;
    rstn = 1;
    t_reset();
    t_alarm();
    t_calendar();
    t_twelve();
    t_inhibit();
    close_out();
  end
endmodule

// ===== core/rtca_match_term.sv
// one term of the alarm condition: stored match value against running count
`timescale 1ns/1ps
`include "rtca_consts.svh"
module rtca_match_term (
  // stored match value and running count
  input wire logic [7:0] match_val,
  input wire logic [7:0] count_val,
  // term result
  output logic hit
);

  logic dont_care;

  assign dont_care = (match_val[7:6] == `RTCA_DONT_CARE_CODE);
  assign hit = dont_care || (match_val == count_val);

endmodule

// ===== core/rtca_regs.sv
// time-of-day and calendar registers with second, minute and hour alarm match
//
// Overview of operation
// - minute match compared; top bits 11 matches
// - hour match compared; top bits 11 matches
// - 12-hour mode: bit 7 is PM flag
// - hour count in bits 6:0, mode range
// - weekday counts 1 Sunday to 7 Saturday
// - weekday encoding unaffected by presentation setting
// - date counts from 1 to month length
// - month counts from 1 to 12
// - year counts 0 to 99 in century
// - counts presented in binary or bcd
// - presentation select: one binary, zero bcd
// - format select: one 24-hour, flag held zero
`timescale 1ns/1ps
`include "rtca_consts.svh"
module rtca_regs (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // byte register port
  input wire logic [`RTCA_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // control from the rest of the clock
  input wire logic binary_presentation_select,
  input wire logic hour_format_24,
  input wire logic update_inhibit,
  input wire logic sec_tick,
  // status
  output logic alarm_evt,
  output logic update_busy
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rtca_pkg::rtca_state_t state_r;
  rtca_pkg::rtca_state_t state_nxt;
  logic [7:0] sec_r;
  logic [7:0] sec_match_r;
  logic [7:0] min_r;
  logic [7:0] minute_match_r;
  logic [7:0] hour_count_r;
  logic [7:0] hour_match_r;
  logic [7:0] weekday_count_r;
  logic [7:0] calendar_date_r;
  logic [7:0] month_count_r;
  logic [7:0] year_count_r;
  logic [7:0] rdata_r;
  logic alarm_evt_r;
  logic update_busy_r;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  logic wr_sec;
  logic wr_sec_match;
  logic wr_min;
  logic wr_min_match;
  logic wr_hour;
  logic wr_hour_match;
  logic wr_wday;
  logic wr_date;
  logic wr_month;
  logic wr_year;
  logic [7:0] hour_wdata;

  assign wr_sec = reg_wr && (reg_addr == `RTCA_OFS_SEC);
  assign wr_sec_match = reg_wr && (reg_addr == `RTCA_OFS_SEC_MATCH);
  assign wr_min = reg_wr && (reg_addr == `RTCA_OFS_MIN);
  assign wr_min_match = reg_wr && (reg_addr == `RTCA_OFS_MIN_MATCH);
  assign wr_hour = reg_wr && (reg_addr == `RTCA_OFS_HOUR);
  assign wr_hour_match = reg_wr && (reg_addr == `RTCA_OFS_HOUR_MATCH);
  assign wr_wday = reg_wr && (reg_addr == `RTCA_OFS_WEEKDAY);
  assign wr_date = reg_wr && (reg_addr == `RTCA_OFS_DATE);
  assign wr_month = reg_wr && (reg_addr == `RTCA_OFS_MONTH);
  assign wr_year = reg_wr && (reg_addr == `RTCA_OFS_YEAR);

  // flag held zero
  // in 24-hour mode the half-day flag cannot be set by a write
  assign hour_wdata = hour_format_24 ? {1'b0, reg_wdata[`RTCA_HOUR_MSB:0]} : reg_wdata;

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;

  always_comb begin
    if (reg_addr == `RTCA_OFS_SEC) begin
      rd_mux = sec_r;
    end else if (reg_addr == `RTCA_OFS_SEC_MATCH) begin
      rd_mux = sec_match_r;
    end else if (reg_addr == `RTCA_OFS_MIN) begin
      rd_mux = min_r;
    end else if (reg_addr == `RTCA_OFS_MIN_MATCH) begin
      rd_mux = minute_match_r;
    end else if (reg_addr == `RTCA_OFS_HOUR) begin
      rd_mux = hour_count_r;
    end else if (reg_addr == `RTCA_OFS_HOUR_MATCH) begin
      rd_mux = hour_match_r;
    end else if (reg_addr == `RTCA_OFS_WEEKDAY) begin
      rd_mux = weekday_count_r;
    end else if (reg_addr == `RTCA_OFS_DATE) begin
      rd_mux = calendar_date_r;
    end else if (reg_addr == `RTCA_OFS_MONTH) begin
      rd_mux = month_count_r;
    end else if (reg_addr == `RTCA_OFS_YEAR) begin
      rd_mux = year_count_r;
    end else begin
      rd_mux = `RTCA_RDATA_UNMAPPED;
    end
  end

  // ----------------------------------------------------------------
  // month length
  // ----------------------------------------------------------------
  function automatic logic [7:0] days_in_month(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    // every multiple of four in 2000..2099 is a leap year, 2000 included
    leap = (yr[1:0] == 2'b00);
    if (mon == `RTCA_MONTH_FEB) begin
      days_in_month = leap ? `RTCA_DAYS_FEB_LEAP : `RTCA_DAYS_FEB;
    end else if ((mon == `RTCA_MONTH_APR) || (mon == `RTCA_MONTH_JUN) ||
                 (mon == `RTCA_MONTH_SEP) || (mon == `RTCA_MONTH_NOV)) begin
      days_in_month = `RTCA_DAYS_SHORT;
    end else begin
      days_in_month = `RTCA_DAYS_LONG;
    end
  endfunction

  logic [7:0] month_bin;
  logic [7:0] year_bin;
  logic [7:0] date_max;

  assign month_bin = rtca_pkg::rtca_to_bin(month_count_r, binary_presentation_select);
  assign year_bin = rtca_pkg::rtca_to_bin(year_count_r, binary_presentation_select);
  assign date_max = days_in_month(month_bin, year_bin);

  // ----------------------------------------------------------------
  // shared step unit
  // ----------------------------------------------------------------
  logic [7:0] stp_val;
  logic [7:0] stp_lo;
  logic [7:0] stp_hi;
  logic stp_bin;
  logic [7:0] stp_nxt;
  logic [7:0] stp_cur_bin;
  logic stp_wrap;
  logic in_sec;
  logic in_min;
  logic in_hour;
  logic in_wday;
  logic in_date;
  logic in_month;
  logic in_year;

  assign in_sec = (state_r == rtca_pkg::RTCA_SEC);
  assign in_min = (state_r == rtca_pkg::RTCA_MIN);
  assign in_hour = (state_r == rtca_pkg::RTCA_HOUR);
  assign in_wday = (state_r == rtca_pkg::RTCA_WDAY);
  assign in_date = (state_r == rtca_pkg::RTCA_DATE);
  assign in_month = (state_r == rtca_pkg::RTCA_MONTH);
  assign in_year = (state_r == rtca_pkg::RTCA_YEAR);

  assign stp_val = in_sec ? sec_r :
                   in_min ? min_r :
                   in_hour ? {1'b0, hour_count_r[`RTCA_HOUR_MSB:0]} :
                   in_wday ? weekday_count_r :
                   in_date ? calendar_date_r :
                   in_month ? month_count_r :
                   year_count_r;

  assign stp_lo = in_hour ? (hour_format_24 ? `RTCA_HOUR24_MIN : `RTCA_HOUR12_MIN) :
                  in_wday ? `RTCA_WEEKDAY_MIN :
                  in_date ? `RTCA_DATE_MIN :
                  in_month ? `RTCA_MONTH_MIN :
                  `RTCA_ZERO;

  assign stp_hi = in_sec ? `RTCA_SEC_MAX :
                  in_min ? `RTCA_MIN_MAX :
                  in_hour ? (hour_format_24 ? `RTCA_HOUR24_MAX : `RTCA_HOUR12_MAX) :
                  in_wday ? `RTCA_WEEKDAY_MAX :
                  in_date ? date_max :
                  in_month ? `RTCA_MONTH_MAX :
                  `RTCA_YEAR_MAX;

  assign stp_bin = in_wday ? 1'b1 : binary_presentation_select;

  rtca_step u_step (
    .cur_val(stp_val),
    .lim_lo(stp_lo),
    .lim_hi(stp_hi),
    .bin_mode(stp_bin),
    .nxt_val(stp_nxt),
    .cur_bin(stp_cur_bin),
    .wrap(stp_wrap)
  );

  // ----------------------------------------------------------------
  // hour handling
  // ----------------------------------------------------------------
  logic pm_now;
  logic pm_turn;
  logic hour_carry;
  logic [7:0] hour_stepped;

  assign pm_now = hour_count_r[`RTCA_HALF_DAY_BIT];
  assign pm_turn = (stp_cur_bin == `RTCA_HOUR12_PM_TURN);
  // pm flag toggles at 11 to 12
  // 12-hour day ends on 11 pm to 12 am, not on the 12 to 1 wrap
  assign hour_carry = hour_format_24 ? stp_wrap : (pm_turn && pm_now);
  assign hour_stepped = hour_format_24 ? {1'b0, stp_nxt[`RTCA_HOUR_MSB:0]} :
                        {pm_now ^ pm_turn, stp_nxt[`RTCA_HOUR_MSB:0]};

  // ----------------------------------------------------------------
  // alarm terms
  // ----------------------------------------------------------------
  logic [7:0] term_match [3];
  logic [7:0] term_count [3];
  logic [2:0] term_hit;
  logic alarm_all;

  assign term_match[0] = sec_match_r;
  assign term_count[0] = sec_r;
  assign term_match[1] = minute_match_r;
  assign term_count[1] = min_r;
  // hour term
  // hour match holds the half-day flag too, so am and pm differ
  assign term_match[2] = hour_match_r;
  assign term_count[2] = hour_count_r;

  for (genvar g = 0; g < 3; g++) begin : g_term
    rtca_match_term u_term (
      .match_val(term_match[g]),
      .count_val(term_count[g]),
      .hit(term_hit[g])
    );
  end

  assign alarm_all = &term_hit;

  // ----------------------------------------------------------------
  // carry chain sequencer
  // ----------------------------------------------------------------
  // per-second carry chain
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rtca_pkg::RTCA_IDLE: begin
        if (sec_tick && !update_inhibit) begin
          state_nxt = rtca_pkg::RTCA_SEC;
        end
      end
      rtca_pkg::RTCA_SEC,
      rtca_pkg::RTCA_MIN,
      rtca_pkg::RTCA_DATE,
      rtca_pkg::RTCA_MONTH: begin
        state_nxt = stp_wrap ? rtca_pkg::rtca_state_t'(state_r + 4'h1) : rtca_pkg::RTCA_MATCH;
      end
      rtca_pkg::RTCA_HOUR: begin
        state_nxt = hour_carry ? rtca_pkg::RTCA_WDAY : rtca_pkg::RTCA_MATCH;
      end
      rtca_pkg::RTCA_WDAY: begin
        state_nxt = rtca_pkg::RTCA_DATE;
      end
      rtca_pkg::RTCA_YEAR: begin
        state_nxt = rtca_pkg::RTCA_MATCH;
      end
      default: begin
        state_nxt = rtca_pkg::RTCA_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= rtca_pkg::RTCA_IDLE;
      update_busy_r <= 1'b0;
      alarm_evt_r <= 1'b0;
      rdata_r <= `RTCA_RST_VAL;
    end else begin
      state_r <= state_nxt;
      update_busy_r <= (state_nxt != rtca_pkg::RTCA_IDLE);
      alarm_evt_r <= (state_r == rtca_pkg::RTCA_MATCH) && alarm_all;
      if (reg_rd) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // storage; a software write beats the step in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sec_r <= `RTCA_RST_VAL;
      sec_match_r <= `RTCA_RST_VAL;
      min_r <= `RTCA_RST_VAL;
      minute_match_r <= `RTCA_RST_VAL;
      hour_count_r <= `RTCA_RST_VAL;
      hour_match_r <= `RTCA_RST_VAL;
      weekday_count_r <= `RTCA_RST_VAL;
      calendar_date_r <= `RTCA_RST_VAL;
      month_count_r <= `RTCA_RST_VAL;
      year_count_r <= `RTCA_RST_VAL;
    end else begin
      sec_r <= wr_sec ? reg_wdata : (in_sec ? stp_nxt : sec_r);
      sec_match_r <= wr_sec_match ? reg_wdata : sec_match_r;
      min_r <= wr_min ? reg_wdata : (in_min ? stp_nxt : min_r);
      minute_match_r <= wr_min_match ? reg_wdata : minute_match_r;
      hour_count_r <= wr_hour ? hour_wdata : (in_hour ? hour_stepped : hour_count_r);
      hour_match_r <= wr_hour_match ? reg_wdata : hour_match_r;
      weekday_count_r <= wr_wday ? reg_wdata : (in_wday ? stp_nxt : weekday_count_r);
      calendar_date_r <= wr_date ? reg_wdata : (in_date ? stp_nxt : calendar_date_r);
      month_count_r <= wr_month ? reg_wdata : (in_month ? stp_nxt : month_count_r);
      year_count_r <= wr_year ? reg_wdata : (in_year ? stp_nxt : year_count_r);
    end
  end

  assign reg_rdata = rdata_r;
  assign alarm_evt = alarm_evt_r;
  assign update_busy = update_busy_r;

endmodule

// ===== core/rtca_step.sv
// single count step with wrap, in binary or bcd presentation
`timescale 1ns/1ps
module rtca_step (
  // count in and limits (limits in binary)
  input wire logic [7:0] cur_val,
  input wire logic [7:0] lim_lo,
  input wire logic [7:0] lim_hi,
  input wire logic bin_mode,
  // stepped count out
  output logic [7:0] nxt_val,
  output logic [7:0] cur_bin,
  output logic wrap
);

  logic [7:0] inc_bin;

  assign cur_bin = rtca_pkg::rtca_to_bin(cur_val, bin_mode);
  // out-of-range values written by software also wrap rather than run away
  assign wrap = (cur_bin >= lim_hi);
  assign inc_bin = wrap ? lim_lo : 8'(cur_bin + 8'h01);
  assign nxt_val = rtca_pkg::rtca_from_bin(inc_bin, bin_mode);

endmodule

// ===== shared/rtca_consts.svh
// register offsets, field positions, reset values and count limits of the calendar block
`ifndef RTCA_CONSTS_SVH
`define RTCA_CONSTS_SVH

`define RTCA_ADDR_W 6
`define RTCA_OFS_SEC 6'h00
`define RTCA_OFS_SEC_MATCH 6'h01
`define RTCA_OFS_MIN 6'h02
`define RTCA_OFS_MIN_MATCH 6'h03
`define RTCA_OFS_HOUR 6'h04
`define RTCA_OFS_HOUR_MATCH 6'h05
`define RTCA_OFS_WEEKDAY 6'h06
`define RTCA_OFS_DATE 6'h07
`define RTCA_OFS_MONTH 6'h08
`define RTCA_OFS_YEAR 6'h09

`define RTCA_RST_VAL 8'h00
`define RTCA_RDATA_UNMAPPED 8'h00

`define RTCA_HALF_DAY_BIT 7
`define RTCA_HOUR_MSB 6
`define RTCA_DONT_CARE_CODE 2'h3

`define RTCA_SEC_MAX 8'h3B
`define RTCA_MIN_MAX 8'h3B
`define RTCA_HOUR24_MIN 8'h00
`define RTCA_HOUR24_MAX 8'h17
`define RTCA_HOUR12_MIN 8'h01
`define RTCA_HOUR12_MAX 8'h0C
`define RTCA_HOUR12_PM_TURN 8'h0B
`define RTCA_WEEKDAY_MIN 8'h01
`define RTCA_WEEKDAY_MAX 8'h07
`define RTCA_DATE_MIN 8'h01
`define RTCA_MONTH_MIN 8'h01
`define RTCA_MONTH_MAX 8'h0C
`define RTCA_MONTH_FEB 8'h02
`define RTCA_MONTH_APR 8'h04
`define RTCA_MONTH_JUN 8'h06
`define RTCA_MONTH_SEP 8'h09
`define RTCA_MONTH_NOV 8'h0B
`define RTCA_YEAR_MIN 8'h00
`define RTCA_YEAR_MAX 8'h63
`define RTCA_DAYS_LONG 8'h1F
`define RTCA_DAYS_SHORT 8'h1E
`define RTCA_DAYS_FEB 8'h1C
`define RTCA_DAYS_FEB_LEAP 8'h1D
`define RTCA_ZERO 8'h00

`endif

// ===== shared/rtca_pkg.sv
// types and code conversions shared by the calendar block
package rtca_pkg;

  typedef logic [7:0] rtca_byte_t;

  // one field of the carry chain is stepped in each state from RTCA_SEC to RTCA_YEAR
  typedef enum logic [3:0] {
    RTCA_IDLE,
    RTCA_SEC,
    RTCA_MIN,
    RTCA_HOUR,
    RTCA_WDAY,
    RTCA_DATE,
    RTCA_MONTH,
    RTCA_YEAR,
    RTCA_MATCH
  } rtca_state_t;

  function automatic rtca_byte_t rtca_to_bin(input rtca_byte_t v, input logic bin_mode);
    rtca_byte_t tens;
    tens = {4'h0, v[7:4]};
    if (bin_mode) begin
      return v;
    end
    return 8'((tens << 3) + (tens << 1) + {4'h0, v[3:0]});
  endfunction

  function automatic rtca_byte_t rtca_from_bin(input rtca_byte_t v, input logic bin_mode);
    rtca_byte_t tens;
    tens = v / 8'h0A;
    if (bin_mode) begin
      return v;
    end
    return {tens[3:0], 4'(v - 8'(tens * 8'h0A))};
  endfunction

endpackage
